// ==== core/lsc_pkg.sv ====
// shared constants and types for the line unit system side channel
package lsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // drive monitor
  localparam int MON_LIMIT = 128; // bit periods without a pulse before fault
  localparam int MON_CW = 8; // counter width, holds MON_LIMIT
  localparam logic [MON_CW-1:0] MON_LIMIT_V = 8'h80;
  localparam logic [MON_CW-1:0] MON_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // loss of lock measurement
  localparam int LOCK_WIN_DEF = 1000; // reference edges per measurement window
  localparam int LOCK_TOL_PPT = 5; // 0.5 percent, in parts per thousand
  localparam int PPT = 1000;
  localparam int LOCK_CW = 16;
  localparam logic [LOCK_CW-1:0] LOCK_CNT_RST = 16'h0000;
  localparam logic LOL_RST = 1'b1; // unlocked until the first window closes

  ////////////////////////////////////////////////////////////////////////////
  // line code substitution lengths
  localparam int RUN_B3ZS = 3; // 00V or B0V
  localparam int RUN_HDB3 = 4; // 000V or B00V

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer
  localparam int FIFO_DEPTH = 4;

  // symbol held in the transmit encoder pipe
  typedef enum logic [1:0] {
    SYM_SPACE,
    SYM_MARK,
    SYM_BAL,
    SYM_VIOL
  } lsc_sym_t;

  // one bit period of rail data (line pair or system pair)
  typedef struct packed {
    logic pos;
    logic neg;
  } lsc_rail_t;

  localparam lsc_rail_t RAIL_IDLE = 2'h0;

endpackage

// ==== core/lsc_channel.sv ====
// one channel of system side transmit and receive logic, with its transmit buffer
//
// Notes on behaviour
// - dual rail: negative rail sampled on each rising transmit clock edge, pulsed by the framer.
// - single rail: the negative rail input is ignored; framer ties it low.
// - positive mark drives positive line output high, negative mark the other one.
// - both line outputs float when global or channel transmit enable is low.
// - drive fault goes high after 128 bit periods with no bipolar pulse.
// - drive fault goes low when a pulse was seen within the last 128 periods.
// - internal monitoring ignores the external monitor inputs.
// - signal absent output follows the loss of signal defect.
// - lock lost is high while recovered rate deviates 0.5 percent or more.
// - dual rail: positive pulse in gives a one period positive output pulse.
// - dual rail: negative pulse in gives a one period negative output pulse.
// - single rail: decoded data leaves serially on the positive output.
// - single rail: negative output flags code violations and excess zeros.
// - receive positive and negative outputs change on the rising edge of the receive clock output.
// - single rail transmit data is encoded B3ZS, or HDB3 in E3 mode.
// - dual rail transmit data passes without substitution encoding.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo with valid/ready on both sides
module lsc_fifo
  import lsc_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // pointers must wrap cleanly, so other depths are refused when elaborating
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
    $error("lsc_fifo: depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_q != rd_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// channel top
module lsc_channel
  import lsc_pkg::*;
#(
  parameter int LOCK_WIN = LOCK_WIN_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // system configuration, on sys_clk_i
  input wire logic single_rail_i,
  input wire logic hdb3_mode_i,
  input wire logic internal_monitor_i,
  input wire logic channel_tx_on_i,
  // transmit pins
  input wire logic transmit_power_on_i,
  input wire logic transmit_clock_in_i,
  input wire logic transmit_positive_rail_i,
  input wire logic transmit_negative_rail_i,
  output logic transmit_ready_o,
  output logic line_out_positive_o,
  output logic line_out_positive_oe_o,
  output logic line_out_negative_o,
  output logic line_out_negative_oe_o,
  input wire logic monitor_positive_in_i,
  input wire logic monitor_negative_in_i,
  output logic drive_fault_out_o,
  // receive pins
  input wire logic signal_absent_defect_i,
  input wire logic recovered_clock_in_i,
  input wire logic reference_clock_in_i,
  input wire logic rx_line_positive_i,
  input wire logic rx_line_negative_i,
  output logic receive_signal_absent_out_o,
  output logic receive_lock_lost_out_o,
  output logic receive_clock_out_o,
  output logic receive_positive_rail_o,
  output logic receive_negative_or_violation_o
);

  // tolerance must be at least one edge and fit the counters
  localparam int LOCK_TOL_X = LOCK_TOL_PPT * LOCK_WIN; // compared against diff * PPT
  if (LOCK_WIN * LOCK_TOL_PPT < PPT || LOCK_WIN >= (1 << (LOCK_CW - 1))) begin : g_bad_win
    $error("lsc_channel: LOCK_WIN out of range");
  end

  // polarity to line pair
  function automatic lsc_rail_t pol_rail(input logic positive);
    lsc_rail_t r;
    r.pos = positive;
    r.neg = ~positive;
    return r;
  endfunction

  // true when the symbol is a space
  function automatic logic is_space(input lsc_sym_t s);
    return s == SYM_SPACE;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // system domain: pin synchronisers
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_q;
  logic pwr_s, rec_s, ref_s, rxp_s, rxn_s, los_s;

  always_ff @(posedge sys_clk_i) begin
    pin_meta_q <= {transmit_power_on_i, recovered_clock_in_i, reference_clock_in_i,
                   rx_line_positive_i, rx_line_negative_i, signal_absent_defect_i};
    pin_q <= pin_meta_q;
  end
  assign {pwr_s, rec_s, ref_s, rxp_s, rxn_s, los_s} = pin_q;

  //////////////////////////////////////////////////////////////////////////////
  // system domain: transmit enable and line tri-state
  logic tx_en_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_en_q <= 1'b0;
    end else begin
      tx_en_q <= pwr_s && channel_tx_on_i;
    end
  end
  assign line_out_positive_oe_o = tx_en_q;
  assign line_out_negative_oe_o = tx_en_q;

  //////////////////////////////////////////////////////////////////////////////
  // link domain: reset and configuration crossing
  logic lrst_meta_q;
  logic lrst_q;
  logic [3:0] lcfg_meta_q;
  logic [3:0] lcfg_q;
  logic l_single, l_hdb3, l_intmon, l_txen;

  always_ff @(posedge transmit_clock_in_i) begin
    lrst_meta_q <= rst_i;
    lrst_q <= lrst_meta_q;
  end

  // quasi static levels, two flops each
  always_ff @(posedge transmit_clock_in_i) begin
    lcfg_meta_q <= {single_rail_i, hdb3_mode_i, internal_monitor_i, tx_en_q};
    lcfg_q <= lcfg_meta_q;
  end
  assign {l_single, l_hdb3, l_intmon, l_txen} = lcfg_q;

  //////////////////////////////////////////////////////////////////////////////
  // link domain: rail capture into the transmit buffer
  lsc_rail_t tx_in_q;
  lsc_rail_t fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;

  always_ff @(posedge transmit_clock_in_i) begin
    if (lrst_q) begin
      tx_in_q <= RAIL_IDLE;
    end else begin
      tx_in_q.pos <= transmit_positive_rail_i;
      tx_in_q.neg <= transmit_negative_rail_i && !l_single;
    end
  end

  // drained only while the driver is enabled, so a disabled channel fills it
  assign fifo_pop = fifo_out_valid && l_txen;

  lsc_fifo #(
    .WIDTH($bits(lsc_rail_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(transmit_clock_in_i),
    .rst_i(lrst_q),
    .in_valid_i(!lrst_q),
    .in_ready_o(transmit_ready_o),
    .in_data_i(tx_in_q),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(l_txen),
    .out_data_o(fifo_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // link domain: substitution encoder and line driver
  lsc_sym_t pipe_q [3];
  lsc_sym_t nxt [4];
  lsc_sym_t emit;
  logic run_zero;
  logic last_pol_q; // polarity of the last pulse sent, 1 = positive
  logic odd_q; // odd count of pulses since the last violation
  lsc_rail_t line_q;

  always_comb begin
    nxt[0] = fifo_out.pos ? SYM_MARK : SYM_SPACE;
    nxt[1] = pipe_q[0];
    nxt[2] = pipe_q[1];
    nxt[3] = pipe_q[2];
    run_zero = !fifo_out.pos && is_space(pipe_q[0]) && is_space(pipe_q[1])
               && (!l_hdb3 || is_space(pipe_q[2]));
    if (run_zero) begin
      nxt[0] = SYM_VIOL;
      if (!odd_q && l_hdb3) begin
        nxt[3] = SYM_BAL;
      end else if (!odd_q) begin
        nxt[2] = SYM_BAL;
      end
    end
    emit = l_hdb3 ? nxt[3] : nxt[2];
  end

  // pipe and pulse state advance once per buffered bit, in single rail mode only
  always_ff @(posedge transmit_clock_in_i) begin
    if (lrst_q) begin
      pipe_q <= '{SYM_SPACE, SYM_SPACE, SYM_SPACE};
      last_pol_q <= 1'b0;
      odd_q <= 1'b0;
    end else if (fifo_pop && l_single) begin
      pipe_q <= '{nxt[0], nxt[1], nxt[2]};
      if (emit == SYM_MARK || emit == SYM_BAL) begin
        last_pol_q <= !last_pol_q;
        odd_q <= !odd_q;
      end else if (emit == SYM_VIOL) begin
        odd_q <= 1'b0;
      end
    end
  end

  // line pair register
  always_ff @(posedge transmit_clock_in_i) begin
    if (lrst_q || !fifo_pop) begin
      line_q <= RAIL_IDLE;
    end else if (!l_single) begin
      line_q <= fifo_out;
    end else begin
      case (emit)
        SYM_MARK: line_q <= pol_rail(!last_pol_q);
        SYM_BAL: line_q <= pol_rail(!last_pol_q);
        SYM_VIOL: line_q <= pol_rail(last_pol_q);
        default: line_q <= RAIL_IDLE;
      endcase
    end
  end
  assign line_out_positive_o = line_q.pos;
  assign line_out_negative_o = line_q.neg;

  //////////////////////////////////////////////////////////////////////////////
  // link domain: drive monitor
  logic [1:0] mon_meta_q;
  logic [1:0] mon_q;
  logic mon_pulse;
  logic [MON_CW-1:0] mon_cnt_q;
  logic fault_q;

  always_ff @(posedge transmit_clock_in_i) begin
    mon_meta_q <= {monitor_positive_in_i, monitor_negative_in_i};
    mon_q <= mon_meta_q;
  end

  assign mon_pulse = l_intmon ? ((line_q.pos || line_q.neg) && l_txen)
                              : (mon_q[1] || mon_q[0]);

  always_ff @(posedge transmit_clock_in_i) begin
    if (lrst_q || mon_pulse) begin
      mon_cnt_q <= MON_RST;
    end else if (mon_cnt_q != MON_LIMIT_V) begin
      mon_cnt_q <= mon_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge transmit_clock_in_i) begin
    if (lrst_q) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= !mon_pulse && (mon_cnt_q == MON_LIMIT_V);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: drive fault crossing
  logic fault_meta_q;
  logic fault_s_q;

  always_ff @(posedge sys_clk_i) begin
    fault_meta_q <= fault_q;
    fault_s_q <= fault_meta_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      drive_fault_out_o <= 1'b0;
    end else begin
      drive_fault_out_o <= fault_s_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: recovered and reference clock edges
  logic rec_d1_q;
  logic ref_d1_q;
  logic rec_edge;
  logic ref_edge;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rec_d1_q <= 1'b0;
      ref_d1_q <= 1'b0;
    end else begin
      rec_d1_q <= rec_s;
      ref_d1_q <= ref_s;
    end
  end
  assign rec_edge = rec_s && !rec_d1_q;
  assign ref_edge = ref_s && !ref_d1_q;
  assign receive_clock_out_o = rec_d1_q; // rises with each data update

  //////////////////////////////////////////////////////////////////////////////
  // system domain: loss of signal
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      receive_signal_absent_out_o <= 1'b0;
    end else begin
      receive_signal_absent_out_o <= los_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: loss of lock, recovered edges counted per reference window
  logic [LOCK_CW-1:0] ref_cnt_q;
  logic [LOCK_CW-1:0] rec_cnt_q;
  logic [LOCK_CW-1:0] rec_total;
  logic [LOCK_CW-1:0] diff;
  logic win_end;

  assign win_end = ref_edge && (ref_cnt_q == LOCK_CW'(LOCK_WIN - 1));
  assign rec_total = rec_cnt_q + LOCK_CW'(rec_edge);
  assign diff = (rec_total > LOCK_CW'(LOCK_WIN)) ? rec_total - LOCK_CW'(LOCK_WIN)
                                                 : LOCK_CW'(LOCK_WIN) - rec_total;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || win_end) begin
      ref_cnt_q <= LOCK_CNT_RST;
      rec_cnt_q <= LOCK_CNT_RST;
    end else begin
      ref_cnt_q <= ref_cnt_q + LOCK_CW'(ref_edge);
      if (rec_edge && rec_cnt_q != '1) begin
        rec_cnt_q <= rec_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      receive_lock_lost_out_o <= LOL_RST;
    end else if (win_end) begin
      receive_lock_lost_out_o <= (32'(diff) * PPT) >= LOCK_TOL_X;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: receive decoder, stepped on each rising recovered clock edge
  logic [3:0] dec_q;
  logic [4:0] nd;
  logic rx_pulse;
  logic rx_viol;
  logic rx_legal;
  logic rx_last_pol_q;
  logic [2:0] zrun_q;
  logic rx_exz;
  logic rx_lcv;

  always_comb begin
    rx_pulse = rxp_s || rxn_s;
    rx_viol = rx_pulse && (rxp_s == rx_last_pol_q);
    rx_legal = !dec_q[0] && (!hdb3_mode_i || !dec_q[1]);
    nd = {dec_q, rx_pulse};
    if (rx_viol && rx_legal) begin
      nd[0] = 1'b0; // substituted zeros restored
      nd[1] = 1'b0;
      nd[2] = 1'b0;
      if (hdb3_mode_i) begin
        nd[3] = 1'b0; // only the four bit code reaches this far back
      end
    end
    rx_lcv = (rxp_s && rxn_s) || (rx_viol && !rx_legal);
    rx_exz = !rx_pulse && (zrun_q == 3'(hdb3_mode_i ? RUN_HDB3 - 1 : RUN_B3ZS - 1));
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dec_q <= 4'h0;
      rx_last_pol_q <= 1'b0;
      zrun_q <= 3'h0;
    end else if (rec_edge) begin
      dec_q <= nd[3:0];
      if (rx_pulse) begin
        rx_last_pol_q <= rxp_s;
        zrun_q <= 3'h0;
      end else if (zrun_q != 3'h7) begin
        zrun_q <= zrun_q + 1'b1;
      end
    end
  end

  // output register, changes only with the receive clock rising
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      receive_positive_rail_o <= 1'b0;
      receive_negative_or_violation_o <= 1'b0;
    end else if (rec_edge) begin
      if (!single_rail_i) begin
        receive_positive_rail_o <= rxp_s;
        receive_negative_or_violation_o <= rxn_s;
      end else begin
        receive_positive_rail_o <= hdb3_mode_i ? nd[4] : nd[3];
        receive_negative_or_violation_o <= rx_lcv || rx_exz;
      end
    end
  end

endmodule

// ==== tb/lsc_channel_props.sv ====
// concurrent checks on the ports of one channel
`timescale 1ns/1ns
module lsc_channel_chk
  import lsc_pkg::*;
#(
  parameter int LOCK_WIN = LOCK_WIN_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic internal_monitor_i,
  input wire logic channel_tx_on_i,
  input wire logic transmit_power_on_i,
  input wire logic transmit_clock_in_i,
  input wire logic line_out_positive_o,
  input wire logic line_out_positive_oe_o,
  input wire logic line_out_negative_o,
  input wire logic line_out_negative_oe_o,
  input wire logic drive_fault_out_o,
  input wire logic signal_absent_defect_i,
  input wire logic receive_signal_absent_out_o,
  input wire logic receive_lock_lost_out_o,
  input wire logic receive_clock_out_o,
  input wire logic receive_positive_rail_o,
  input wire logic receive_negative_or_violation_o
);
  logic [7:0] gap_q;

  ////////////////////////////////////////////////////////////////////////////
  // link bits since the last mark, counted only while monitoring internally
  always_ff @(posedge transmit_clock_in_i) begin
    if (rst_i || !internal_monitor_i || line_out_positive_o || line_out_negative_o) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  oe_bit_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !channel_tx_on_i |=> !line_out_positive_oe_o && !line_out_negative_oe_o)
    else $error("line driven with channel bit off");
  oe_pin_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!transmit_power_on_i) [*4] |-> !line_out_positive_oe_o && !line_out_negative_oe_o)
    else $error("line driven with global enable off");
  oe_on_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (transmit_power_on_i && channel_tx_on_i) [*4] |-> line_out_positive_oe_o)
    else $error("line not driven while enabled");
  mark_excl_a: assert property (@(posedge transmit_clock_in_i) disable iff (rst_i)
    !(line_out_positive_o && line_out_negative_o))
    else $error("both line outputs high");
  fault_set_a: assert property (@(posedge transmit_clock_in_i) disable iff (rst_i)
    gap_q > 8'hb4 |-> drive_fault_out_o)
    else $error("no fault after long quiet line");
  fault_clr_a: assert property (@(posedge transmit_clock_in_i) disable iff (rst_i)
    internal_monitor_i && (line_out_positive_o || line_out_negative_o)
    |-> ##[1:60] !drive_fault_out_o)
    else $error("fault stays after a mark");
  los_set_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    signal_absent_defect_i [*4] |-> receive_signal_absent_out_o)
    else $error("signal absent not shown");
  los_clr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!signal_absent_defect_i) [*4] |-> !receive_signal_absent_out_o)
    else $error("signal absent stuck");
  rx_upd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !$rose(receive_clock_out_o)
    |-> $stable({receive_positive_rail_o, receive_negative_or_violation_o}))
    else $error("receive rails moved off the clock edge");

  fault_c: cover property (@(posedge sys_clk_i) $rose(drive_fault_out_o));
  lock_c: cover property (@(posedge sys_clk_i) $fell(receive_lock_lost_out_o));
  oe_c: cover property (@(posedge sys_clk_i) $rose(line_out_positive_oe_o));
endmodule

bind lsc_channel lsc_channel_chk #(.LOCK_WIN(LOCK_WIN)) chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .internal_monitor_i(internal_monitor_i),
  .channel_tx_on_i(channel_tx_on_i), .transmit_power_on_i(transmit_power_on_i),
  .transmit_clock_in_i(transmit_clock_in_i), .line_out_positive_o(line_out_positive_o),
  .line_out_positive_oe_o(line_out_positive_oe_o), .line_out_negative_o(line_out_negative_o),
  .line_out_negative_oe_o(line_out_negative_oe_o), .drive_fault_out_o(drive_fault_out_o),
  .signal_absent_defect_i(signal_absent_defect_i),
  .receive_signal_absent_out_o(receive_signal_absent_out_o),
  .receive_lock_lost_out_o(receive_lock_lost_out_o),
  .receive_clock_out_o(receive_clock_out_o), .receive_positive_rail_o(receive_positive_rail_o),
  .receive_negative_or_violation_o(receive_negative_or_violation_o));

// ==== tb/lsc_framer_model.sv ====
// framer model: free running transmit clock and one shot rail words
`timescale 1ns/1ns
module lsc_framer_model
  import lsc_pkg::*;
(
  input wire logic single_rail_i,
  input wire logic go_i,
  input wire lsc_rail_t shot_i,
  output logic transmit_clock_in_o,
  output lsc_rail_t rails_o
);
  logic go_q = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // transmit clock is the line timing source, so it never stops
  initial begin
    transmit_clock_in_o = 1'b0;
    rails_o = RAIL_IDLE;
    forever begin
      #7 transmit_clock_in_o = 1'b1;
      #8 transmit_clock_in_o = 1'b0;
    end
  end

  // one word per toggle of go_i just after a rise, zeros otherwise
  always @(posedge transmit_clock_in_o) begin
    go_q <= go_i;
    rails_o.pos <= (go_i != go_q) && shot_i.pos;
    rails_o.neg <= (go_i != go_q) && shot_i.neg && !single_rail_i;
  end
endmodule

// ==== tb/lsc_channel_test.sv ====
// self-checking bench for one line unit channel
`timescale 1ns/1ns
module lsc_channel_test;
  import lsc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, single_rail = 1'b0, hdb3 = 1'b0, imon = 1'b0;
  logic ch_on = 1'b0, pwr_on = 1'b0, mon_run = 1'b0, signal_absent_defect = 1'b0, rec = 1'b0, refc = 1'b0;
  logic go = 1'b0, rck_q = 1'b0, tx_clk, oe_p, oe_n, lo_p, lo_n, fault, rx_los;
  logic lock_lost, rck, rx_p, rx_n, tx_rdy;
  lsc_rail_t shot_w = RAIL_IDLE, mon = RAIL_IDLE, rx_w = RAIL_IDLE, rails;
  lsc_rail_t rx_q[$];
  int num_errors = 0, cmp_count = 0, cyc = 0, rec_half = 3, rec_cnt = 0, ref_cnt = 0;
  int tx_pos = 0, tx_neg = 0, tx_bits = 0, rx_ones = 0, rx_negs = 0, d;

  always #50 sys_clk = ~sys_clk;

  lsc_channel #(.LOCK_WIN(400)) uut (
    .sys_clk_i(sys_clk), .rst_i(rst), .single_rail_i(single_rail), .hdb3_mode_i(hdb3),
    .internal_monitor_i(imon), .channel_tx_on_i(ch_on), .transmit_power_on_i(pwr_on),
    .transmit_clock_in_i(tx_clk), .transmit_positive_rail_i(rails.pos),
    .transmit_negative_rail_i(rails.neg), .transmit_ready_o(tx_rdy),
    .line_out_positive_o(lo_p), .line_out_positive_oe_o(oe_p), .line_out_negative_o(lo_n),
    .line_out_negative_oe_o(oe_n), .monitor_positive_in_i(mon.pos),
    .monitor_negative_in_i(mon.neg), .drive_fault_out_o(fault),
    .signal_absent_defect_i(signal_absent_defect), .recovered_clock_in_i(rec), .reference_clock_in_i(refc),
    .rx_line_positive_i(rx_w.pos), .rx_line_negative_i(rx_w.neg),
    .receive_signal_absent_out_o(rx_los), .receive_lock_lost_out_o(lock_lost),
    .receive_clock_out_o(rck), .receive_positive_rail_o(rx_p),
    .receive_negative_or_violation_o(rx_n));

  lsc_framer_model framer (.single_rail_i(single_rail), .go_i(go), .shot_i(shot_w),
    .transmit_clock_in_o(tx_clk), .rails_o(rails));

  ////////////////////////////////////////////////////////////////////////////
  // divided recovered and reference clocks, receive line words, monitor pins
  always @(negedge sys_clk) begin
    ref_cnt <= (ref_cnt == 2) ? 0 : ref_cnt + 1;
    if (ref_cnt == 2) refc <= !refc;
    rec_cnt <= (rec_cnt >= rec_half - 1) ? 0 : rec_cnt + 1;
    if (rec_cnt >= rec_half - 1) begin
      rec <= !rec;
      if (rec) rx_w <= (rx_q.size() != 0) ? rx_q.pop_front() : RAIL_IDLE;
    end
    mon <= mon_run ? {mon.neg, !mon.neg} : RAIL_IDLE;
  end

  // tally line marks per link bit
  always @(posedge tx_clk) begin
    tx_bits++;
    tx_pos += (lo_p === 1'b1);
    tx_neg += (lo_n === 1'b1);
  end

  // tally receive rails per receive clock rise, and cut a hang short
  always @(posedge sys_clk) begin
    rck_q <= rck;
    if (rck === 1'b1 && rck_q === 1'b0) begin
      rx_ones += (rx_p === 1'b1);
      rx_negs += (rx_n === 1'b1);
    end
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic shot(input lsc_rail_t w);
    shot_w = w;
    go = !go;
    ticks(2);
  endtask

  task automatic clear();
    tx_pos = 0;
    tx_neg = 0;
    tx_bits = 0;
    rx_ones = 0;
    rx_negs = 0;
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // enables gate the drivers; a stalled buffer refuses then drains
  task automatic t_enable();
    pwr_on = 1'b1;
    ticks(5);
    check({oe_p, oe_n, tx_rdy}, 3'h0, "oe bit off");
    ch_on = 1'b1;
    ticks(5);
    check({oe_p, oe_n, tx_rdy}, 3'h7, "oe on");
    pwr_on = 1'b0;
    ticks(5);
    check({oe_p, oe_n}, 2'h0, "oe global off");
    pwr_on = 1'b1;
    ticks(5);
  endtask

  // coded dual rail words pass one for one
  task automatic t_tx_dual();
    single_rail = 1'b0;
    for (int m = 0; m < 2; m++) begin
      hdb3 = m[0];
      ticks(5);
      clear();
      shot(2'h2);
      shot(2'h1);
      ticks(5);
      check(tx_pos, 16'h1, "positive marks");
      check(tx_neg, 16'h1, "negative marks");
    end
  endtask

  // all zeros in single rail: 2 marks per 3 bits, or per 4 in the other code
  task automatic t_tx_single();
    single_rail = 1'b1;
    for (int m = 0; m < 2; m++) begin
      hdb3 = m[0];
      ticks(5);
      clear();
      ticks(20);
      d = tx_pos + tx_neg - (m ? tx_bits / 2 : tx_bits * 2 / 3);
      check(d > -3 && d < 3 && tx_pos != 0 && tx_neg != 0, 1'h1, "mark density");
    end
  endtask

  task automatic t_monitor();
    single_rail = 1'b0;
    imon = 1'b1;
    mon_run = 1'b1;
    ticks(40);
    check(fault, 1'h1, "fault, pins ignored");
    shot(2'h2);
    ticks(8);
    check(fault, 1'h0, "fault cleared");
    shot(2'h1);
    ticks(14);
    check(fault, 1'h0, "count restart");
    imon = 1'b0;
    ticks(40);
    check(fault, 1'h0, "pins active");
    mon_run = 1'b0;
    ticks(40);
    check(fault, 1'h1, "pins quiet");
  endtask

  task automatic t_los();
    signal_absent_defect = 1'b1;
    ticks(5);
    check(rx_los, 1'h1, "absent set");
    signal_absent_defect = 1'b0;
    ticks(5);
    check(rx_los, 1'h0, "absent clear");
  endtask

  task automatic t_rx_dual();
    single_rail = 1'b0;
    ticks(60);
    clear();
    rx_q = '{2'h2, 2'h0, 2'h1};
    ticks(60);
    check(rx_ones, 16'h1, "rx positive");
    check(rx_negs, 16'h1, "rx negative");
  endtask

  task automatic t_rx_single();
    single_rail = 1'b1;
    for (int i = 0; i < 40; i++) rx_q.push_back(i[0] ? 2'h1 : 2'h2);
    ticks(48);
    clear();
    ticks(72);
    check(rx_ones, 16'hc, "rx data");
    check(rx_negs, 16'h0, "rx flag clean");
    clear();
    ticks(240);
    check(rx_negs != 0, 1'h1, "rx zeros flag");
    // three bit substitution after a mark: both marks survive, one flag after the run
    hdb3 = 1'b0;
    clear();
    rx_q = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h1};
    ticks(80);
    check(rx_ones, 16'h2, "rx zeros restored");
    check(rx_negs, 16'h1, "rx substitution not flagged");
  endtask

  task automatic t_lock();
    ticks(5000);
    check(lock_lost, 1'h0, "locked");
    rec_half = 2;
    ticks(5000);
    check(lock_lost, 1'h1, "lock lost");
  endtask

  initial begin
    ticks(2);
    rst = 1'b0;
    ticks(1);
    check({oe_p, fault, lock_lost}, 3'h1, "reset values");
    t_enable();
    t_tx_dual();
    t_tx_single();
    t_monitor();
    t_los();
    t_rx_dual();
    t_rx_single();
    t_lock();
    close_out();
  end
endmodule
